// *** rtl/fifo_wave_pkg.sv ***
//////////////////////////////////////////////////////////////////////////////
// Purpose: Constants for the waveform-port / slave-FIFO pin block
// Assumes: 100 MHz system clock, classic Wishbone register access
// Notes: Register offsets are byte addresses of aligned 32-bit words
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Ready inputs two to five serve the waveform engine as wait conditions and are otherwise seen only in the pins register.
// - The mode field routes either waveform outputs zero to two or the three FIFO flags onto the shared pins.
// - In slave-FIFO mode the first shared pin shows the fill-level flag of the FIFO picked by the select pins.
// - In slave-FIFO mode the second shared pin shows the full flag of the FIFO picked by the select pins.
// - In slave-FIFO mode the third shared pin shows the empty flag of the FIFO picked by the select pins.
// - Waveform outputs three to five have their own pins; three may float, four and five are always driven.
// - The interface clock times the slave-FIFO strobes and the waveform engine; the flags follow the block clock.
// - With internal clocking selected the block drives the interface clock pin at 30 or 48 MHz.
// - The invert bit flips the interface clock polarity for both internal and external sources.
// - In slave-FIFO mode ready inputs zero and one become read and write strobes of programmable polarity.
//////////////////////////////////////////////////////////////////////////////
package fifo_wave_pkg;
  // Register map
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_STEP = 8'h04;
  localparam logic [7:0] ADDR_PINS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  // Interface config fields
  localparam int CFG_MODE = 0;
  localparam int CFG_WR_POL = 2;
  localparam int CFG_RD_POL = 3;
  localparam int CFG_INVERT = 4;
  localparam int CFG_FREQ = 5;
  localparam int CFG_INTERNAL = 7;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  // Mode field codes
  localparam logic [1:0] MODE_WAVE = 2'h2;
  localparam logic [1:0] MODE_SLAVE = 2'h3;
  // Step register fields
  localparam int STEP_TRI3 = 6;
  localparam int STEP_IDX = 8;
  localparam int STEP_GO = 15;
  localparam logic [5:0] PATTERN_RESET = 6'h3F;
  // Interrupt bits
  localparam int IRQ_WAVE = 0;
  localparam int IRQ_RD = 1;
  localparam int IRQ_WR = 2;
  localparam int IRQ_BITS = 3;
  // Interface clock synthesis: phase accumulator increments
  localparam int CLK_MHZ = 100;
  localparam int INTERFACE_CLOCK_SLOW_MHZ = 30;
  localparam int INTERFACE_CLOCK_FAST_MHZ = 48;
  localparam int NCO_BITS = 16;
  localparam logic [NCO_BITS-1:0] NCO_INC_SLOW = NCO_BITS'((INTERFACE_CLOCK_SLOW_MHZ * (1 << NCO_BITS)) / CLK_MHZ);
  localparam logic [NCO_BITS-1:0] NCO_INC_FAST = NCO_BITS'((INTERFACE_CLOCK_FAST_MHZ * (1 << NCO_BITS)) / CLK_MHZ);
  typedef enum logic [0:0] {WAVE_IDLE = 1'b0, WAVE_WAIT = 1'b1} wave_state_t;
endpackage

// *** rtl/fifo_wave_port.sv ***
//////////////////////////////////////////////////////////////////////////////
// Purpose: Pin block for the waveform engine ports, slave-FIFO flags and interface clock
// Assumes: Pins are asynchronous to clk_i; FIFO status comes from logic on clk_i
// Notes: Internal interface clock is synthesised by an accumulator and carries jitter
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
module fifo_wave_port
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [5:0] wave_ready_in_i,
  input wire logic [1:0] fifo_select_pins_i,
  input wire logic interface_clock_i,
  output logic interface_clock_o,
  output logic interface_clock_oe_o,
  output logic [5:0] wave_control_out_o,
  output logic [3:0] wave_control_oe_o,
  input wire logic [3:0] fifo_prog_i,
  input wire logic [3:0] fifo_full_i,
  input wire logic [3:0] fifo_empty_i,
  output logic [1:0] fifo_addr_o,
  output logic slave_read_strobe_o,
  output logic slave_write_strobe_o,
  output logic irq_o
);
  logic [7:0] interface_config;
  logic [5:0] pattern;
  logic tri3;
  localparam int IRQ_BITS_W = fifo_wave_pkg::IRQ_BITS;
  localparam int NCO_BITS_W = fifo_wave_pkg::NCO_BITS;
  logic [2:0] ready_idx;
  logic [IRQ_BITS_W-1:0] irq_status;
  logic [IRQ_BITS_W-1:0] irq_mask;
  logic [8:0] sync1;
  logic [8:0] sync2;
  logic [NCO_BITS_W-1:0] phase;
  logic clk_eff_q;
  logic if_edge;
  logic clk_eff;
  logic [1:0] mode;
  logic slave_mode;
  logic internal;
  logic rd_active;
  logic wr_active;
  logic ready_hit;
  logic go_write;
  logic bus_req;
  logic wr_cfg;
  logic rd_status;
  logic [IRQ_BITS_W-1:0] irq_set;
  fifo_wave_pkg::wave_state_t state;
  fifo_wave_pkg::wave_state_t next_state;

  //////////////////////////////////////////////////////////////////////////
  // Decoded configuration
  assign mode = interface_config[fifo_wave_pkg::CFG_MODE +: 2];
  assign slave_mode = (mode == fifo_wave_pkg::MODE_SLAVE);
  assign internal = interface_config[fifo_wave_pkg::CFG_INTERNAL];
  assign bus_req = cyc_i && stb_i && !ack_o;
  assign wr_cfg = bus_req && we_i && sel_i[0] && (adr_i == fifo_wave_pkg::ADDR_CONFIG);
  assign go_write = bus_req && we_i && sel_i[1] && (adr_i == fifo_wave_pkg::ADDR_STEP)
    && dat_i[fifo_wave_pkg::STEP_GO];
  assign rd_status = bus_req && !we_i && (adr_i == fifo_wave_pkg::ADDR_IRQ_STATUS);

  //////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers: ready pins, FIFO select pins, interface clock pin
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1 <= 9'h000;
      sync2 <= 9'h000;
    end
    else
    begin
      sync1 <= {interface_clock_i, fifo_select_pins_i, wave_ready_in_i};
      sync2 <= sync1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Interface clock synthesis; accumulator runs always so switching is glitch-limited
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      phase <= '0;
    else if (interface_config[fifo_wave_pkg::CFG_FREQ +: 2] == 2'h0)
      phase <= phase + fifo_wave_pkg::NCO_INC_SLOW;
    else
      phase <= phase + fifo_wave_pkg::NCO_INC_FAST;
  end

  // Effective clock: own or pin, then optional inversion
  assign clk_eff = (internal ? phase[NCO_BITS_W-1] : sync2[8])
    ^ interface_config[fifo_wave_pkg::CFG_INVERT];
  assign if_edge = clk_eff && !clk_eff_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      clk_eff_q <= 1'b0;
      interface_clock_o <= 1'b0;
      interface_clock_oe_o <= 1'b0;
    end
    else
    begin
      clk_eff_q <= clk_eff;
      interface_clock_o <= phase[NCO_BITS_W-1] ^ interface_config[fifo_wave_pkg::CFG_INVERT];
      interface_clock_oe_o <= internal;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Slave strobes on ready zero and one, polarity from config
  assign rd_active = (sync2[0] == interface_config[fifo_wave_pkg::CFG_RD_POL]);
  assign wr_active = (sync2[1] == interface_config[fifo_wave_pkg::CFG_WR_POL]);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      slave_read_strobe_o <= 1'b0;
      slave_write_strobe_o <= 1'b0;
      fifo_addr_o <= 2'h0;
    end
    else
    begin
      slave_read_strobe_o <= slave_mode && if_edge && rd_active;
      slave_write_strobe_o <= slave_mode && if_edge && wr_active;
      fifo_addr_o <= sync2[7:6];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Waveform engine: one step waits on a ready input, then applies its pattern
  // Ready zero and one are strobes in slave mode, so they never satisfy a wait there
  assign ready_hit = (ready_idx > 3'h5) ? 1'b1 : (sync2[ready_idx] && !(slave_mode && ready_idx < 3'h2));

  always_comb
  begin
    next_state = state;
    case (state)
      fifo_wave_pkg::WAVE_IDLE:
        if (go_write)
          next_state = fifo_wave_pkg::WAVE_WAIT;
      fifo_wave_pkg::WAVE_WAIT:
        if (if_edge && ready_hit)
          next_state = fifo_wave_pkg::WAVE_IDLE;
      default:
        next_state = fifo_wave_pkg::WAVE_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state <= fifo_wave_pkg::WAVE_IDLE;
    else
      state <= next_state;
  end

  // Step register: pattern is staged but reaches the pins only when the wait ends
  logic [5:0] staged;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      staged <= fifo_wave_pkg::PATTERN_RESET;
      pattern <= fifo_wave_pkg::PATTERN_RESET;
      tri3 <= 1'b0;
      ready_idx <= 3'h0;
    end
    else
    begin
      if (bus_req && we_i && (adr_i == fifo_wave_pkg::ADDR_STEP) && state == fifo_wave_pkg::WAVE_IDLE)
      begin
        if (sel_i[0])
        begin
          staged <= dat_i[5:0];
          tri3 <= dat_i[fifo_wave_pkg::STEP_TRI3];
        end
        if (sel_i[1])
          ready_idx <= dat_i[fifo_wave_pkg::STEP_IDX +: 3];
      end
      if (state == fifo_wave_pkg::WAVE_WAIT && if_edge && ready_hit)
        pattern <= staged;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin drive: shared pins carry waveform outputs or FIFO flags
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wave_control_out_o <= fifo_wave_pkg::PATTERN_RESET;
      wave_control_oe_o <= 4'h0;
    end
    else
    begin
      if (slave_mode)
      begin
        wave_control_out_o[0] <= fifo_prog_i[sync2[7:6]];
        wave_control_out_o[1] <= fifo_full_i[sync2[7:6]];
        wave_control_out_o[2] <= fifo_empty_i[sync2[7:6]];
      end
      else
        wave_control_out_o[2:0] <= pattern[2:0];
      wave_control_out_o[5:3] <= pattern[5:3];
      // Shared pins float unless a mode claims them; output three may float by choice
      wave_control_oe_o[2:0] <= {3{mode[1]}};
      wave_control_oe_o[3] <= !tri3;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Configuration and mask registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      interface_config <= fifo_wave_pkg::CONFIG_RESET;
      irq_mask <= '0;
    end
    else
    begin
      if (wr_cfg)
        interface_config <= dat_i[7:0];
      if (bus_req && we_i && sel_i[0] && adr_i == fifo_wave_pkg::ADDR_IRQ_MASK)
        irq_mask <= dat_i[IRQ_BITS_W-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sticky events; a read clears, but an event in the same cycle survives
  assign irq_set = {slave_write_strobe_o, slave_read_strobe_o,
    (state == fifo_wave_pkg::WAVE_WAIT) && (next_state == fifo_wave_pkg::WAVE_IDLE)};

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_status <= '0;
      irq_o <= 1'b0;
    end
    else
    begin
      irq_status <= (rd_status ? '0 : irq_status) | irq_set;
      irq_o <= |(irq_status & irq_mask);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Wishbone slave: ack one cycle after the request, unmapped reads give zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= bus_req;
      dat_o <= 32'h0000_0000;
      if (bus_req && !we_i)
        case (adr_i)
          fifo_wave_pkg::ADDR_CONFIG: dat_o[7:0] <= interface_config;
          fifo_wave_pkg::ADDR_STEP: dat_o[15:0] <= {state == fifo_wave_pkg::WAVE_WAIT, 4'h0,
            ready_idx, 1'b0, tri3, staged};
          fifo_wave_pkg::ADDR_PINS: dat_o[15:0] <= {6'h00, sync2[7:6], 2'h0, sync2[5:0]};
          fifo_wave_pkg::ADDR_IRQ_STATUS: dat_o[IRQ_BITS_W-1:0] <= irq_status;
          fifo_wave_pkg::ADDR_IRQ_MASK: dat_o[IRQ_BITS_W-1:0] <= irq_mask;
          default: dat_o <= 32'h0000_0000;
        endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_level_flag;
    @(posedge clk_i) disable iff (rst_i)
    $past(slave_mode) |-> wave_control_out_o[0] == $past(fifo_prog_i[sync2[7:6]]);
  endproperty
  a_level_flag: assert property (p_level_flag) else $error("level flag wrong");

  property p_full_flag;
    @(posedge clk_i) disable iff (rst_i)
    $past(slave_mode) |-> wave_control_out_o[1] == $past(fifo_full_i[sync2[7:6]]);
  endproperty
  a_full_flag: assert property (p_full_flag) else $error("full flag wrong");

  property p_empty_flag;
    @(posedge clk_i) disable iff (rst_i)
    $past(slave_mode) |-> wave_control_out_o[2] == $past(fifo_empty_i[sync2[7:6]]);
  endproperty
  a_empty_flag: assert property (p_empty_flag) else $error("empty flag wrong");

  property p_shared_wave;
    @(posedge clk_i) disable iff (rst_i)
    (mode == fifo_wave_pkg::MODE_WAVE) |=> wave_control_out_o[2:0] == $past(pattern[2:0]) && &wave_control_oe_o[2:0];
  endproperty
  a_shared_wave: assert property (p_shared_wave) else $error("shared pins not waveform");

  property p_wave_control_out3_float;
    @(posedge clk_i) disable iff (rst_i)
    tri3 ##1 tri3 |-> !wave_control_oe_o[3];
  endproperty
  a_wave_control_out3_float: assert property (p_wave_control_out3_float) else $error("output three drives");

  property p_clk_drive;
    @(posedge clk_i) disable iff (rst_i)
    $rose(internal) |=> interface_clock_oe_o ##1 (interface_clock_oe_o || !internal);
  endproperty
  a_clk_drive: assert property (p_clk_drive) else $error("clock pin not driven");

  property p_clk_invert;
    @(posedge clk_i) disable iff (rst_i)
    1'b1 |=> interface_clock_o == ($past(phase[NCO_BITS_W-1]) ^ $past(interface_config[fifo_wave_pkg::CFG_INVERT]));
  endproperty
  a_clk_invert: assert property (p_clk_invert) else $error("clock polarity wrong");

  property p_read_strobe;
    @(posedge clk_i) disable iff (rst_i)
    slave_mode && if_edge && rd_active |=> slave_read_strobe_o ##1 !slave_read_strobe_o;
  endproperty
  a_read_strobe: assert property (p_read_strobe) else $error("read strobe missing");

  property p_wave_step;
    @(posedge clk_i) disable iff (rst_i)
    state == fifo_wave_pkg::WAVE_WAIT && if_edge && ready_hit |=> pattern == $past(staged) && irq_status[0];
  endproperty
  a_wave_step: assert property (p_wave_step) else $error("step did not complete");

  c_slave_read: cover property (@(posedge clk_i) disable iff (rst_i) slave_read_strobe_o);
  c_wave_done: cover property (@(posedge clk_i) disable iff (rst_i) $fell(state == fifo_wave_pkg::WAVE_WAIT));
  c_irq: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
endmodule

// *** bench/far_end_model.sv ***
//////////////////////////////////////////////////////////////////////////////
// Purpose: Far-side party of the waveform / slave-FIFO pins
// Assumes: Free-running external interface clock of 80 ns period
// Notes: Pins change asynchronously to the block clock, as on a real board
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
module far_end_model
(
  input wire logic clk_oe_i,
  input wire logic clk_out_i,
  output logic clk_pin_o,
  output logic [5:0] ready_o,
  output logic [1:0] select_o
);
  logic ext_clk = 1'b0;

  //////////////////////////////////////////////////////////////////////////////
  // The interface clock runs free; it times strobes and the engine
  always #40 ext_clk = ~ext_clk;

  // The far party drives the pin only while the block leaves it as an input
  assign clk_pin_o = clk_oe_i ? clk_out_i : ext_clk;

  // Ready pins, zero and one of which act as read and write strobes in slave mode
  initial
  begin
    ready_o = 6'h00;
    select_o = 2'h0;
  end

  // Pins change only when the bench asks, so scenarios stay deterministic
  task set_pins(input logic [5:0] r, input logic [1:0] s);
    ready_o <= r;
    select_o <= s;
  endtask
endmodule

// *** bench/fifo_wave_port_pins_tb.sv ***
//////////////////////////////////////////////////////////////////////////////
// Purpose: Self-checking bench of the waveform-port pin block
// Assumes: Classic Wishbone register access, 100 MHz clock
// Notes: Edge counts allow a small margin for accumulator jitter
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
module fifo_waveform_port_pins_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [31:0] dat_o;
  logic ack_o;
  logic [5:0] ready;
  logic [1:0] select;
  logic clk_pin;
  logic interface_clock_o;
  logic interface_clock_oe_o;
  logic [5:0] wave_control_out_o;
  logic [3:0] wave_control_oe_o;
  logic [3:0] fifo_prog_i = 4'h5;
  logic [3:0] fifo_full_i = 4'h3;
  logic [3:0] fifo_empty_i = 4'h9;
  logic [1:0] fifo_addr_o;
  logic slave_read_strobe_o;
  logic slave_write_strobe_o;
  logic irq_o;
  logic [31:0] rd;
  int fails = 0;
  int comparisons = 0;
  int n_clk;
  int n_rd;
  int n_wr;

  always #5 clk_i = ~clk_i;

  fifo_wave_port dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .wave_ready_in_i(ready), .fifo_select_pins_i(select), .interface_clock_i(clk_pin),
    .interface_clock_o(interface_clock_o), .interface_clock_oe_o(interface_clock_oe_o),
    .wave_control_out_o(wave_control_out_o), .wave_control_oe_o(wave_control_oe_o),
    .fifo_prog_i(fifo_prog_i), .fifo_full_i(fifo_full_i), .fifo_empty_i(fifo_empty_i),
    .fifo_addr_o(fifo_addr_o), .slave_read_strobe_o(slave_read_strobe_o),
    .slave_write_strobe_o(slave_write_strobe_o), .irq_o(irq_o));

  far_end_model partner_u (.clk_oe_i(interface_clock_oe_o), .clk_out_i(interface_clock_o),
    .clk_pin_o(clk_pin), .ready_o(ready), .select_o(select));

  //////////////////////////////////////////////////////////////////////////////
  // Single classic cycle; waits for ack under a bound, never assumes latency
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'hF;
    dat_i <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 50);
    rd = dat_o;
    if (n >= 50)
      fails++;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask

  // Range check for counts that carry jitter
  task rng(input int got, input int lo, input int hi);
    comparisons++;
    if (got < lo || got > hi)
    begin
      $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      fails++;
    end
  endtask

  // Counts clock-pin rises and strobe pulses, sampled at each block clock edge
  task count(input int cycles);
    logic prev;
    prev = interface_clock_o;
    n_clk = 0;
    n_rd = 0;
    n_wr = 0;
    repeat (cycles)
    begin
      @(posedge clk_i);
      n_clk += (interface_clock_o === 1'b1 && prev === 1'b0) ? 1 : 0;
      n_rd += (slave_read_strobe_o === 1'b1) ? 1 : 0;
      n_wr += (slave_write_strobe_o === 1'b1) ? 1 : 0;
      prev = interface_clock_o;
    end
  endtask

  // Polls the busy bit of the step register, bounded
  task wait_step();
    int n;
    n = 0;
    do
    begin
      wb(1'b0, fifo_wave_pkg::ADDR_STEP, 32'h0000_0000);
      n++;
    end
    while (rd[fifo_wave_pkg::STEP_GO] !== 1'b0 && n < 40);
    if (n >= 40)
      fails++;
  endtask

  task close_out();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Watchdog: the tests need about 42 us, so 200 us leaves ample margin
  initial
  begin
    #200000;
    fails++;
    close_out();
  end

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({26'h0, wave_control_out_o}, {26'h0, fifo_wave_pkg::PATTERN_RESET});
    chk({28'h0, wave_control_oe_o}, 32'h0000_0000);
    chk({31'h0, interface_clock_oe_o}, 32'h0000_0000);
    wb(1'b0, fifo_wave_pkg::ADDR_CONFIG, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    wb(1'b1, 8'h14, 32'hFFFF_FFFF);
    wb(1'b0, 8'h14, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    // Slave mode: shared pins carry the flags of the selected FIFO
    wb(1'b1, fifo_wave_pkg::ADDR_CONFIG, 32'h0000_0003);
    for (int s = 0; s < 4; s++)
    begin
      partner_u.set_pins(6'h00, 2'(s));
      repeat (6) @(posedge clk_i);
      chk({29'h0, wave_control_out_o[2:0]}, {29'h0, fifo_empty_i[s], fifo_full_i[s], fifo_prog_i[s]});
      chk({29'h0, wave_control_oe_o[2:0]}, 32'h0000_0007);
      chk({30'h0, fifo_addr_o}, 32'(s));
      wb(1'b0, fifo_wave_pkg::ADDR_PINS, 32'h0000_0000);
      chk({30'h0, rd[9:8]}, 32'(s));
    end
    // Read strobe active high, write strobe active high but idle
    wb(1'b1, fifo_wave_pkg::ADDR_IRQ_MASK, 32'h0000_0002);
    wb(1'b1, fifo_wave_pkg::ADDR_CONFIG, 32'h0000_000F);
    partner_u.set_pins(6'h01, 2'h0);
    count(800);
    rng(n_rd, 97, 101);
    rng(n_wr, 0, 0);
    chk({31'h0, irq_o}, 32'h0000_0001);
    // Low read polarity idles the high read pin; the high write pin fires writes
    wb(1'b1, fifo_wave_pkg::ADDR_CONFIG, 32'h0000_0007);
    partner_u.set_pins(6'h03, 2'h0);
    count(200);
    rng(n_rd, 0, 0);
    rng(n_wr, 23, 26);
    // Park both strobes and let the pipeline drain so the clear below stays clear
    partner_u.set_pins(6'h01, 2'h0);
    repeat (6) @(posedge clk_i);
    // Both strobe events are sticky since slave mode began
    wb(1'b0, fifo_wave_pkg::ADDR_IRQ_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0006);
    wb(1'b0, fifo_wave_pkg::ADDR_IRQ_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk({31'h0, irq_o}, 32'h0000_0000);
    // Waveform mode: a step waits on ready pin two, then applies its pattern
    wb(1'b1, fifo_wave_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
    wb(1'b1, fifo_wave_pkg::ADDR_CONFIG, 32'h0000_0002);
    partner_u.set_pins(6'h3B, 2'h0);
    wb(1'b1, fifo_wave_pkg::ADDR_STEP, 32'h0000_8215);
    repeat (40) @(posedge clk_i);
    wb(1'b0, fifo_wave_pkg::ADDR_STEP, 32'h0000_0000);
    chk({31'h0, rd[fifo_wave_pkg::STEP_GO]}, 32'h0000_0001);
    chk({31'h0, irq_o}, 32'h0000_0000);
    partner_u.set_pins(6'h04, 2'h0);
    wait_step();
    chk({26'h0, wave_control_out_o}, 32'h0000_0015);
    chk({28'h0, wave_control_oe_o}, 32'h0000_000F);
    chk({31'h0, irq_o}, 32'h0000_0001);
    wb(1'b0, fifo_wave_pkg::ADDR_IRQ_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    // Tri-state bit floats output three, four and five stay driven
    wb(1'b1, fifo_wave_pkg::ADDR_STEP, 32'h0000_876A);
    wait_step();
    chk({26'h0, wave_control_out_o}, 32'h0000_002A);
    chk({28'h0, wave_control_oe_o}, 32'h0000_0007);
    // Internal clock at both rates, with and without inversion; mode zero frees the shared pins
    wb(1'b1, fifo_wave_pkg::ADDR_CONFIG, 32'h0000_0080);
    count(1000);
    rng(n_clk, 298, 302);
    chk({31'h0, interface_clock_oe_o}, 32'h0000_0001);
    chk({29'h0, wave_control_oe_o[2:0]}, 32'h0000_0000);
    wb(1'b1, fifo_wave_pkg::ADDR_CONFIG, 32'h0000_00A0);
    count(1000);
    rng(n_clk, 478, 482);
    wb(1'b1, fifo_wave_pkg::ADDR_CONFIG, 32'h0000_0090);
    count(1000);
    rng(n_clk, 298, 302);
    wb(1'b1, fifo_wave_pkg::ADDR_CONFIG, 32'h0000_0000);
    repeat (3) @(posedge clk_i);
    chk({31'h0, interface_clock_oe_o}, 32'h0000_0000);
    close_out();
  end
endmodule
